//--- core/cbii_params.svh
`ifndef CBII_PARAMS_SVH
`define CBII_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CBII_OFS_CTRL     12'h000
`define CBII_OFS_IMGLO    12'h004
`define CBII_OFS_IMGHI    12'h008
`define CBII_OFS_STATUS   12'h00C
`define CBII_OFS_MASK     12'h010
`define CBII_OFS_CFG      12'h014

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CBII_CTRL_DIAGCOPY 0
`define CBII_CTRL_RESET    32'h0000_0000
`define CBII_MASK_RESET    2'h0
`define CBII_CFG_COUNT_RST 5'h10
`define CBII_BIT_COIL      0
`define CBII_BIT_BREAKER   1
`define CBII_BIT_SPARE     2
`define CBII_BIT_OFFLINE   3
`define CBII_EVT_CHANGE    0
`define CBII_EVT_DIAG      1
`define CBII_SLAVES        16
`define CBII_IMG_BYTES     8

`endif

//--- core/cbii_pkg.sv
package cbii_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Raw per-slave state as delivered by the bus engine
  typedef struct packed {
    logic coil;      // Coil feedback, 1 = coil on
    logic breaker;   // Breaker, 1 = switched on
  } cbii_slave_t;

  // One 4-bit image nibble
  typedef struct packed {
    logic offline;   // Top bit
    logic spare;     // Always zero
    logic breaker;   // Breaker state
    logic coil;      // Coil feedback
  } cbii_nibble_t;

  // Image update sequencer
  typedef enum logic [1:0] {
    CBII_IDLE    = 2'b00,
    CBII_CAPTURE = 2'b01,
    CBII_PUBLISH = 2'b10
  } cbii_state_t;

endpackage : cbii_pkg

//--- core/cbii_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-stage synchroniser for a bundle of levels
// ----------------------------------------------------------------
module cbii_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // System clock
  input  wire logic             reset,  // Sync reset, active high
  input  wire logic [WIDTH-1:0] din,    // Asynchronous levels
  output logic      [WIDTH-1:0] dout    // Synchronised levels
);

  logic [WIDTH-1:0] stage1_reg;  // First stage, read only by second

  // Two flops; only the second stage is visible outside
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_reg <= '0;
      dout       <= '0;
    end else begin
      stage1_reg <= din;
      dout       <= stage1_reg;
    end
  end

endmodule : cbii_sync

//--- core/cbii_nibble.sv
`timescale 1ns/1ps
`include "cbii_params.svh"
// ----------------------------------------------------------------
// Builds one slave nibble from its raw state
// ----------------------------------------------------------------
module cbii_nibble (
  input  wire cbii_pkg::cbii_slave_t  slave,     // Raw slave state
  input  wire logic                   present,   // Slot holds a real slave
  input  wire logic                   diagCopy,  // Copy summary diag bit
  input  wire logic                   diagSum,   // Slave diagnostics summary
  output cbii_pkg::cbii_nibble_t      nibble     // Formatted nibble
);

  // Absent slots read as all zero so stale data never leaks in
  always_comb begin
    nibble         = '0;
    nibble.coil    = present & slave.coil;              // [RULE6]
    nibble.breaker = present & slave.breaker;           // [RULE7]
    nibble.spare   = 1'b0;                              // [RULE10]
    nibble.offline = present & diagCopy & diagSum;      // [RULE8] [RULE9] [RULE10]
  end

endmodule : cbii_nibble

//--- core/cbii_top.sv
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "cbii_params.svh"

// Contract
// (RULE1) Gather slave inputs into gateway process image
// (RULE2) Image is always exactly eight bytes
// (RULE3) One 4-bit nibble per slave, sixteen slots
// (RULE4) Slot one is the physically first slave
// (RULE5) Byte n: slave 2n-1 low, 2n high
// (RULE6) Nibble bit 0 is coil feedback
// (RULE7) Nibble bit 1 is breaker on state
// (RULE8) Nibble bit 3: 1 means offline, diagnostics
// (RULE9) Offline flag only when diagnostic copy enabled
// (RULE10) Unused nibble bits always read zero
// (RULE11) Controller allows feedback delay before mismatch check
module cbii_top (
  input  wire logic         clk,         // 40 MHz system clock
  input  wire logic         reset,       // Sync reset, active high
  // APB slave
  input  wire logic         psel,        // Select
  input  wire logic         penable,     // Access phase
  input  wire logic         pwrite,      // 1 = write
  input  wire logic [11:0]  paddr,       // Byte address
  input  wire logic [31:0]  pwdata,      // Write data
  output logic      [31:0]  prdata,      // Read data
  output logic              pready,      // Always ready
  output logic              pslverr,     // Unmapped address
  // Bus engine side, pins from the field
  input  wire logic [15:0]  coilIn,      // Coil feedback per slave
  input  wire logic [15:0]  breakerIn,   // Breaker state per slave
  input  wire logic         diagSumIn,   // Module slave-diagnostics summary
  input  wire logic         cycleDone,   // Bus cycle complete strobe
  // Gateway side
  output logic      [63:0]  procImage,   // Eight-byte input image
  output logic              imageValid,  // One-cycle pulse on update
  output logic              irq          // Level interrupt
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [15:0] coilSync;     // Synchronised coil bits
  logic [15:0] breakerSync;  // Synchronised breaker bits
  logic        diagSync;     // Synchronised diag summary
  logic        doneSync;     // Synchronised cycle strobe level
  logic        doneDly_reg;  // Previous doneSync for edge detect

  // Field pins come from another domain, so two flops each
  cbii_sync #(.WIDTH(34)) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   ({coilIn, breakerIn, diagSumIn, cycleDone}),
    .dout  ({coilSync, breakerSync, diagSync, doneSync})
  );

  // Edge detector on the second stage only
  always_ff @(posedge clk) begin
    if (reset) doneDly_reg <= 1'b0;
    else       doneDly_reg <= doneSync;
  end

  logic cycleEdge;  // Rising edge of cycle-done
  assign cycleEdge = doneSync & ~doneDly_reg;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;    // Control, bit 0 enables diag copy
  logic [4:0]  count_reg;   // Number of slaves present, 0..16
  logic [1:0]  status_reg;  // Sticky events
  logic [1:0]  mask_reg;    // Interrupt mask

  logic        wrEn;        // Write completes this edge
  logic        rdEn;        // Read completes this edge
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;

  // Zero wait states keeps the gateway path simple
  assign pready = 1'b1;

  // Control register write
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= `CBII_CTRL_RESET;
    end else if (wrEn && paddr == `CBII_OFS_CTRL) begin
      ctrl_reg <= {31'h0000_0000, pwdata[`CBII_CTRL_DIAGCOPY]};
    end
  end

  // Slave count register; pwdata[4:0] above sixteen saturates, upper write bits are ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= `CBII_CFG_COUNT_RST;
    end else if (wrEn && paddr == `CBII_OFS_CFG) begin
      if (pwdata[4:0] > 5'h10) count_reg <= 5'h10;
      else                     count_reg <= pwdata[4:0];
    end
  end

  // Mask register
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_reg <= `CBII_MASK_RESET;
    end else if (wrEn && paddr == `CBII_OFS_MASK) begin
      mask_reg <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Image sequencer
  // ----------------------------------------------------------------
  cbii_pkg::cbii_state_t state_reg;   // Current state
  cbii_pkg::cbii_state_t state_next;  // Next state

  // Capture after a bus cycle, publish one cycle later
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cbii_pkg::CBII_IDLE:    if (cycleEdge) state_next = cbii_pkg::CBII_CAPTURE;
      cbii_pkg::CBII_CAPTURE: state_next = cbii_pkg::CBII_PUBLISH;
      cbii_pkg::CBII_PUBLISH: state_next = cbii_pkg::CBII_IDLE;
      default:                state_next = cbii_pkg::CBII_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) state_reg <= cbii_pkg::CBII_IDLE;
    else       state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Per-slave formatting
  // ----------------------------------------------------------------
  cbii_pkg::cbii_slave_t  slaveRaw_reg [`CBII_SLAVES];  // Captured slave state
  logic                   diagCap_reg;                  // Captured summary
  logic [63:0]            imageNext;                    // Assembled image

  // Capture all slaves together so the image is one consistent snapshot
  always_ff @(posedge clk) begin
    if (reset) begin
      diagCap_reg <= 1'b0;
      for (int i = 0; i < `CBII_SLAVES; i++) slaveRaw_reg[i] <= '0;
    end else if (state_reg == cbii_pkg::CBII_CAPTURE) begin  // [RULE1]
      diagCap_reg <= diagSync;
      for (int i = 0; i < `CBII_SLAVES; i++) begin
        slaveRaw_reg[i].coil    <= coilSync[i];
        slaveRaw_reg[i].breaker <= breakerSync[i];
      end
    end
  end

  // Slot i is physical slave i+1; byte i/2, low nibble for even i
  genvar g;
  generate
    for (g = 0; g < `CBII_SLAVES; g++) begin : g_slot
      cbii_pkg::cbii_nibble_t nib;  // Formatted nibble of this slot
      logic present;                // Slot is populated
      assign present = (5'(g) < count_reg);
      cbii_nibble u_nib (
        .slave    (slaveRaw_reg[g]),
        .present  (present),
        .diagCopy (ctrl_reg[`CBII_CTRL_DIAGCOPY]),
        .diagSum  (diagCap_reg),
        .nibble   (nib)
      );
      assign imageNext[4*g +: 4] = nib;  // [RULE3] [RULE4] [RULE5]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Published image
  // ----------------------------------------------------------------
  // Fixed eight-byte image, updated once per bus cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      procImage <= 64'h0000_0000_0000_0000;
    end else if (state_reg == cbii_pkg::CBII_PUBLISH) begin
      procImage <= imageNext;  // [RULE2]
    end
  end

  // Update pulse for the gateway
  always_ff @(posedge clk) begin
    if (reset) imageValid <= 1'b0;
    else       imageValid <= (state_reg == cbii_pkg::CBII_PUBLISH);
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  logic [1:0] evt;  // Event pulses this cycle
  assign evt[`CBII_EVT_CHANGE] = (state_reg == cbii_pkg::CBII_PUBLISH)
                                 && (imageNext != procImage);
  assign evt[`CBII_EVT_DIAG]   = (state_reg == cbii_pkg::CBII_PUBLISH)
                                 && diagCap_reg;

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      status_reg <= 2'b00;
    end else begin
      if (wrEn && paddr == `CBII_OFS_STATUS)
        status_reg <= (status_reg & ~pwdata[1:0]) | evt;
      else
        status_reg <= status_reg | evt;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  logic [31:0] rdData;  // Decoded read value
  logic        mapped;  // Address hits a register

  always_comb begin
    rdData = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `CBII_OFS_CTRL:   rdData = ctrl_reg;
      `CBII_OFS_IMGLO:  rdData = procImage[31:0];
      `CBII_OFS_IMGHI:  rdData = procImage[63:32];
      `CBII_OFS_STATUS: rdData = {30'h0000_0000, status_reg};
      `CBII_OFS_MASK:   rdData = {30'h0000_0000, mask_reg};
      `CBII_OFS_CFG:    rdData = {27'h000_0000, count_reg};
      default:          mapped = 1'b0;  // Unmapped reads zero
    endcase
  end

  // Read data from a flop, but zero-wait needs it now: present comb
  // value in setup so it is stable through the access phase
  logic [31:0] prdata_reg;  // Registered read data
  always_ff @(posedge clk) begin
    if (reset) prdata_reg <= 32'h0000_0000;
    else if (psel & ~penable) prdata_reg <= rdData;
  end

  assign prdata  = rdEn ? prdata_reg : 32'h0000_0000;
  assign pslverr = psel & penable & ~mapped;

endmodule : cbii_top

//--- sim/cbii_top_chk.sv
`timescale 1ns/1ps
// ----
// Port checker
// ----
module cbii_top_chk (
  input wire logic        clk,       // Clock
  input wire logic        reset,     // Sync reset
  input wire logic        psel,      // Select
  input wire logic        penable,   // Access phase
  input wire logic        pwrite,    // Direction
  input wire logic [11:0] paddr,     // Address
  input wire logic [31:0] prdata,    // Read data
  input wire logic        pready,    // Ready
  input wire logic        pslverr,   // Error
  input wire logic        cycleDone, // Update strobe
  input wire logic [63:0] procImage, // Image
  input wire logic        imageValid // Update pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_ready_high: assert property (pready)
    else $error("ready low");
  chk_spare_zero: assert property ((procImage & 64'h4444_4444_4444_4444) == 64'h0)
    else $error("spare bit set");
  chk_image_hold: assert property ($changed(procImage) |-> imageValid)
    else $error("image moved without pulse");
  chk_valid_pulse: assert property (imageValid |=> !imageValid)
    else $error("pulse too long");
  // Sync stages plus capture and publish must land inside this span
  chk_update_due: assert property ($rose(cycleDone) |-> ##[1:8] imageValid)
    else $error("update late");
  chk_err_unmap: assert property (psel && penable && paddr > 12'h014 |->
    pslverr && prdata == 32'h0000_0000)
    else $error("unmapped not refused");
  chk_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("stray error");
  chk_rdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("stray read data");
endmodule : cbii_top_chk

//--- sim/cbii_gw_model.sv
`timescale 1ns/1ps
// ----
// Gateway model: keeps the last published image
// ----
module cbii_gw_model (
  input  wire logic        clk,        // Clock
  input  wire logic        reset,      // Sync reset
  input  wire logic [63:0] procImage,  // Image from block
  input  wire logic        imageValid, // Update pulse
  output logic      [63:0] lastImage   // Image as the controller sees it
);
  // Taken only on the pulse, so feedback is judged after a full update
  always_ff @(posedge clk) begin
    if (reset) begin
      lastImage <= 64'h0;
    end else if (imageValid) begin
      lastImage <= procImage;
    end
  end
endmodule : cbii_gw_model

//--- sim/cbii_top_tb.sv
`timescale 1ns/1ps
`include "cbii_params.svh"
module cbii_top_tb;
  logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic        cycleDone = 0, diagSumIn = 0, pready, pslverr, imageValid, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [15:0] coilIn = '0, breakerIn = '0;
  logic [63:0] procImage, gwImage, e;
  int          err_total = 0, compares = 0, cyc = 0, cnt = 16;
  logic [15:0] pc [4] = '{16'h0001, 16'h8000, 16'hA5C3, 16'h1234};
  logic [15:0] pb [4] = '{16'h0000, 16'hFFFF, 16'h5A3C, 16'h0F0F};
  logic        pd [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  always #12.5 clk = ~clk;
  cbii_top i_cbii_top (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coilIn(coilIn), .breakerIn(breakerIn), .diagSumIn(diagSumIn),
    .cycleDone(cycleDone), .procImage(procImage), .imageValid(imageValid), .irq(irq));
  cbii_gw_model i_cbii_gw_model (.clk(clk), .reset(reset), .procImage(procImage),
    .imageValid(imageValid), .lastImage(gwImage));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; read data is taken at the rising edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) err_total++;
    q = prdata;
    psel <= 0; penable <= 0;
  endtask : apb
  // Pins settle through the synchroniser before the strobe
  task automatic run_img(input logic [15:0] c, input logic [15:0] b, input logic dg);
    int n;
    n = 0;
    @(posedge clk);
    coilIn <= c; breakerIn <= b; diagSumIn <= dg;
    repeat (3) @(posedge clk);
    cycleDone <= 1;
    repeat (2) @(posedge clk);
    cycleDone <= 0;
    do begin @(negedge clk); n++; end while (imageValid !== 1'b1 && n < 20);
    check(imageValid, 1'b1);
  endtask : run_img
  function automatic logic [63:0] exp_img(logic [15:0] c, logic [15:0] b, logic dg);
    logic [63:0] r;
    r = '0;
    for (int k = 0; k < cnt; k++) r[4*k +: 4] = {dg, 1'b0, b[k], c[k]};
    return r;
  endfunction : exp_img
  task end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 0;
    apb(0, `CBII_OFS_CTRL, 0); check(q, 0);
    apb(0, `CBII_OFS_CFG, 0); check(q, 32'h10);
    apb(0, `CBII_OFS_IMGHI, 0); check(q, 0);
    apb(0, 12'h020, 0); check(q, 0);
    apb(1, `CBII_OFS_MASK, 1);
    // Slot 1 coil alone, then slot 16 coil with every breaker on, then mixed; diag copy off for the first two
    for (int i = 0; i < 4; i++) begin
      if (i == 2) apb(1, `CBII_OFS_CTRL, 1);
      run_img(pc[i], pb[i], pd[i]);
      e = exp_img(pc[i], pb[i], i >= 2 && pd[i]);
      check(procImage, e);
      @(negedge clk); check(gwImage, e);
      apb(0, `CBII_OFS_IMGLO, 0); check(q, e[31:0]);
      apb(0, `CBII_OFS_IMGHI, 0); check(q, e[63:32]);
    end
    apb(1, `CBII_OFS_CFG, 32'h14); apb(0, `CBII_OFS_CFG, 0); check(q, 32'h10);
    apb(1, `CBII_OFS_CFG, 4); cnt = 4;
    run_img(16'hFFFF, 16'hFFFF, 1); check(procImage, exp_img(16'hFFFF, 16'hFFFF, 1));
    @(negedge clk); check(irq, 1);
    apb(1, `CBII_OFS_STATUS, 3); apb(0, `CBII_OFS_STATUS, 0); check(q, 0);
    check(irq, 0);
    apb(1, `CBII_OFS_MASK, 0);
    run_img(16'h0002, 16'h0000, 0); @(negedge clk); check(irq, 0);
    apb(0, `CBII_OFS_STATUS, 0); check(q, 1);
    apb(1, `CBII_OFS_MASK, 1); @(negedge clk); check(irq, 1);
    end_of_test();
  end
endmodule : cbii_top_tb
bind cbii_top cbii_top_chk i_cbii_top_chk (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cycleDone(cycleDone), .procImage(procImage), .imageValid(imageValid));
